//--- core/fsp_pkg.sv
// shared constants and types for the flash sector protection block
package fsp_pkg;
	// program memory geometry
	localparam int FSP_FLASH_KB = 60;
	localparam logic [16:0] FSP_TOP = 17'h10000;
	localparam logic [16:0] FSP_SEC0_BASE = 17'h0f000;
	localparam logic [16:0] FSP_SEC1_BASE = 17'h0e000;
	localparam logic [16:0] FSP_KBYTE = 17'h00400;
	localparam int FSP_SEC_KB = 4;
	// sector indices
	localparam logic [1:0] FSP_SEC0 = 2'h0;
	localparam logic [1:0] FSP_SEC1 = 2'h1;
	localparam logic [1:0] FSP_SEC2 = 2'h2;
	// requests from the programming party
	typedef enum logic [1:0] {
		FSP_CMD_PROG = 2'h0,
		FSP_CMD_ERASE_SEC = 2'h1,
		FSP_CMD_ERASE_ALL = 2'h2,
		FSP_CMD_OPT_WR = 2'h3
	} fsp_cmd_t;
	// programming modes
	typedef enum logic [1:0] {
		FSP_MODE_NONE = 2'h0,
		FSP_MODE_TOOL = 2'h1,
		FSP_MODE_ICP = 2'h2,
		FSP_MODE_IAP = 2'h3
	} fsp_mode_t;
	// sequencer states, gray along idle, exec, erase all, option write
	typedef enum logic [1:0] {
		FSP_ST_IDLE = 2'h0,
		FSP_ST_EXEC = 2'h1,
		FSP_ST_WIPE = 2'h3,
		FSP_ST_OPT = 2'h2
	} fsp_state_t;
	// option bit reset value, protection off until the stored option loads
	localparam logic FSP_PROT_RST = 1'h0;
endpackage : fsp_pkg

//--- core/fsp_sector_map.sv
// address to sector decoder for the program memory
`timescale 1ns/100ps
module fsp_sector_map import fsp_pkg::*; #(
	parameter int FLASH_KB = FSP_FLASH_KB
) (
	// byte address
	input wire logic [15:0] addr,
	// decoded sector
	output logic [1:0] sector,
	output logic in_array
);
	localparam logic [16:0] BASE = FSP_TOP - 17'(FLASH_KB) * FSP_KBYTE;

	// sectors 0 and 1 are fixed 4k blocks at the top, sector 2 takes the rest
	always_comb begin
		sector = FSP_SEC2;
		in_array = ({1'b0, addr} >= BASE);
		if ({1'b0, addr} >= FSP_SEC0_BASE) begin
			sector = FSP_SEC0;
		end else if ({1'b0, addr} >= FSP_SEC1_BASE) begin
			sector = FSP_SEC1;
		end
	end
endmodule : fsp_sector_map

//--- core/fsp_protect.sv
// program memory access control: modes, sectors and read-out protection
`timescale 1ns/100ps
module fsp_protect import fsp_pkg::*; #(
	parameter int FLASH_KB = FSP_FLASH_KB
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// mode pins from the board, asynchronous
	input wire logic tool_pin,
	input wire logic icc_pin,
	// in-application enable from the loader
	input wire logic iap_en,
	// stored option bit, valid after reset
	input wire logic nv_prot,
	// request from the programming party
	input wire logic req_valid,
	input wire logic [1:0] req_cmd,
	input wire logic [15:0] req_addr,
	input wire logic [7:0] req_data,
	output logic req_ready,
	output logic req_done,
	output logic req_refused,
	// array macro control
	output logic arr_start,
	output logic [1:0] arr_cmd,
	output logic [1:0] arr_sector,
	output logic [15:0] arr_addr,
	output logic [7:0] arr_data,
	input wire logic arr_done,
	// protection status
	output logic readout_protect_option,
	output logic ext_read_en,
	output logic low_voltage_detector_en
);
	logic rst_meta_q, rst_sync_q;
	logic tool_meta_q, tool_q, icc_meta_q, icc_q;
	logic loaded_q, prot_q, pend_prot_q;
	logic start_q, done_q, refused_q, ready_q, lvd_q, rd_en_q;
	logic [1:0] cmd_q, sec_q;
	logic [15:0] addr_q;
	logic [7:0] data_q;
	fsp_state_t state_q, state_d;
	fsp_mode_t mode;
	logic [1:0] sec;
	logic in_arr, take, allow;
	////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	// two flops on each board pin
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			tool_meta_q <= 1'b0;
			tool_q <= 1'b0;
			icc_meta_q <= 1'b0;
			icc_q <= 1'b0;
		end else begin
			tool_meta_q <= tool_pin;
			tool_q <= tool_meta_q;
			icc_meta_q <= icc_pin;
			icc_q <= icc_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode and permission decode
	fsp_sector_map #(.FLASH_KB(FLASH_KB)) u_map (
		.addr(req_addr),
		.sector(sec),
		.in_array(in_arr)
	);
	// in-circuit programming whenever the synchronised icc pin is high and the tool pin is low
	always_comb begin
		if (tool_q) begin
			mode = FSP_MODE_TOOL;
		end else if (icc_q) begin
			mode = FSP_MODE_ICP;
		end else if (iap_en) begin
			mode = FSP_MODE_IAP;
		end else begin
			mode = FSP_MODE_NONE;
		end
	end
	// which requests the current mode and protection state let through
	always_comb begin
		allow = 1'b0;
		case (fsp_cmd_t'(req_cmd))
			FSP_CMD_PROG, FSP_CMD_ERASE_SEC: begin
				allow = in_arr && !prot_q && (mode != FSP_MODE_NONE)
					&& !(mode == FSP_MODE_IAP && sec == FSP_SEC0);
			end
			FSP_CMD_ERASE_ALL: begin
				allow = !prot_q && (mode == FSP_MODE_TOOL || mode == FSP_MODE_ICP);
			end
			FSP_CMD_OPT_WR: begin
				allow = (mode == FSP_MODE_TOOL || mode == FSP_MODE_ICP);
			end
			default: begin
				allow = 1'b0;
			end
		endcase
	end
	assign take = req_valid && ready_q;

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			FSP_ST_IDLE: begin
				if (take && allow) begin
					if (fsp_cmd_t'(req_cmd) == FSP_CMD_OPT_WR && prot_q && !req_data[0]) begin
						state_d = FSP_ST_WIPE;
					end else begin
						state_d = FSP_ST_EXEC;
					end
				end
			end
			FSP_ST_EXEC: begin
				if (arr_done) begin
					state_d = FSP_ST_IDLE;
				end
			end
			FSP_ST_WIPE: begin
				if (arr_done) begin
					state_d = FSP_ST_OPT;
				end
			end
			FSP_ST_OPT: begin
				if (arr_done) begin
					state_d = FSP_ST_IDLE;
				end
			end
			default: begin
				state_d = FSP_ST_IDLE;
			end
		endcase
	end
	// state register and ready flag
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= FSP_ST_IDLE;
			ready_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ready_q <= loaded_q && state_d == FSP_ST_IDLE && !(take && allow) && !take;
		end
	end
	// array command issue; a refused request never starts the array
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			start_q <= 1'b0;
			cmd_q <= FSP_CMD_PROG;
			sec_q <= FSP_SEC0;
			addr_q <= 16'h0000;
			data_q <= 8'h00;
		end else begin
			start_q <= 1'b0;
			if (state_q == FSP_ST_IDLE && take && allow) begin
				start_q <= 1'b1;
				sec_q <= sec;
				addr_q <= req_addr;
				data_q <= req_data;
				if (state_d == FSP_ST_WIPE) begin
					cmd_q <= FSP_CMD_ERASE_ALL;
				end else begin
					cmd_q <= req_cmd;
				end
			end else if (state_q == FSP_ST_WIPE && arr_done) begin
				start_q <= 1'b1;
				cmd_q <= FSP_CMD_OPT_WR;
			end
		end
	end
	// completion and refusal pulses
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			done_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			done_q <= arr_done && (state_q == FSP_ST_EXEC || state_q == FSP_ST_OPT);
			refused_q <= state_q == FSP_ST_IDLE && take && !allow;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// option bit and its effects
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			loaded_q <= 1'b0;
			prot_q <= FSP_PROT_RST;
			pend_prot_q <= FSP_PROT_RST;
		end else begin
			if (!loaded_q) begin
				loaded_q <= 1'b1;
				prot_q <= nv_prot;
			end
			if (state_q == FSP_ST_IDLE && take && allow) begin
				pend_prot_q <= req_data[0];
			end
			if (arr_done && cmd_q == FSP_CMD_OPT_WR
				&& (state_q == FSP_ST_EXEC || state_q == FSP_ST_OPT)) begin
				prot_q <= pend_prot_q;
			end
		end
	end
	// read path and detector follow protection
	always_ff @(posedge clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rd_en_q <= 1'b0;
			lvd_q <= 1'b0;
		end else begin
			rd_en_q <= loaded_q && !prot_q;
			lvd_q <= loaded_q && !prot_q;
		end
	end

	assign req_ready = ready_q;
	assign req_done = done_q;
	assign req_refused = refused_q;
	assign arr_start = start_q;
	assign arr_cmd = cmd_q;
	assign arr_sector = sec_q;
	assign arr_addr = addr_q;
	assign arr_data = data_q;
	assign readout_protect_option = prot_q;
	assign ext_read_en = rd_en_q;
	assign low_voltage_detector_en = lvd_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_wipe_issue;
		arr_start && arr_cmd == FSP_CMD_ERASE_ALL;
	endsequence
	sequence s_opt_issue;
		arr_start && arr_cmd == FSP_CMD_OPT_WR;
	endsequence

	chk_prot_no_write: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(prot_q && arr_start) |-> arr_cmd == FSP_CMD_OPT_WR || arr_cmd == FSP_CMD_ERASE_ALL)
		else $error("array write started while protected");
	chk_wipe_then_opt: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(state_q == FSP_ST_WIPE && arr_done) |=> s_opt_issue)
		else $error("option write did not follow automatic erase");
	chk_clear_wipes: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(state_q == FSP_ST_IDLE && take && allow && prot_q && req_data[0] == 1'b0
		&& req_cmd == FSP_CMD_OPT_WR) |=> s_wipe_issue)
		else $error("clearing protection did not erase array");
	chk_iap_sec0: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(take && mode == FSP_MODE_IAP && in_arr && sec == FSP_SEC0 && req_cmd != FSP_CMD_OPT_WR)
		|=> refused_q && !arr_start)
		else $error("sector 0 request accepted in application mode");
	chk_refuse_quiet: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(state_q == FSP_ST_IDLE && take && !allow) |=> !arr_start ##1 !arr_start)
		else $error("refused request reached the array");
	chk_lvd_follow: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(loaded_q && prot_q) |=> !low_voltage_detector_en)
		else $error("detector enabled under protection");
	chk_read_block: assert property (@(posedge clk) disable iff (!rst_sync_q)
		$rose(prot_q) |=> !ext_read_en)
		else $error("external read left open under protection");
	chk_prot_source: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(loaded_q && $past(loaded_q) && $changed(prot_q)) |-> $past(arr_done) && $past(cmd_q) == FSP_CMD_OPT_WR)
		else $error("protection changed without option write");
	chk_tool_all: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(take && mode == FSP_MODE_TOOL && !prot_q && in_arr) |=> arr_start && !refused_q)
		else $error("tool mode request refused");
	chk_sec0_map: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(req_addr[15:12] == 4'hf) |-> sec == FSP_SEC0 && in_arr)
		else $error("top 4k not decoded as sector 0");
	chk_sec_kept: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(state_q == FSP_ST_IDLE && take && allow && req_cmd == FSP_CMD_ERASE_SEC) |=> arr_sector == $past(sec))
		else $error("erase issued to wrong sector");
	chk_no_mode_refuse: assert property (@(posedge clk) disable iff (!rst_sync_q)
		(take && mode == FSP_MODE_NONE) |=> refused_q)
		else $error("request accepted outside programming modes");
endmodule : fsp_protect

//--- tb/fsp_array_model.sv
// array macro model: byte image that answers each start after a short random delay
`timescale 1ns/100ps
module fsp_array_model import fsp_pkg::*; #(
	parameter int FLASH_KB = FSP_FLASH_KB
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control from the protection block
	input wire logic arr_start,
	input wire logic [1:0] arr_cmd,
	input wire logic [1:0] arr_sector,
	input wire logic [15:0] arr_addr,
	input wire logic [7:0] arr_data,
	output logic arr_done
);
	logic [7:0] mem [0:65535];
	int wait_n = 0;
	logic busy = 1'b0;
	// return one address range to the erased value
	task automatic wipe(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			mem[i] = 8'hff;
		end
	endtask : wipe
	initial begin
		wipe(0, 65535);
		arr_done = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// one operation at a time, done pulse after one to four cycles
	always @(posedge clk) begin
		arr_done <= 1'b0;
		if (rst_n !== 1'b1) begin
			busy <= 1'b0;
		end else if (arr_start === 1'b1) begin
			busy <= 1'b1;
			wait_n <= 1 + $urandom_range(3);
			case (arr_cmd)
				FSP_CMD_PROG: mem[arr_addr] = mem[arr_addr] & arr_data;
				FSP_CMD_ERASE_SEC: begin
					if (arr_sector == FSP_SEC0) wipe(16'hf000, 16'hffff);
					else if (arr_sector == FSP_SEC1) wipe(16'he000, 16'hefff);
					else wipe(65536 - FLASH_KB * 1024, 16'hdfff);
				end
				FSP_CMD_ERASE_ALL: wipe(65536 - FLASH_KB * 1024, 65535);
				default: ;
			endcase
		end else if (busy) begin
			if (wait_n == 1) begin
				arr_done <= 1'b1;
				busy <= 1'b0;
			end else begin
				wait_n <= wait_n - 1;
			end
		end
	end
endmodule : fsp_array_model

//--- tb/fsp_protect_tb.sv
// self-checking bench for the flash sector protection block
`timescale 1ns/100ps
module fsp_protect_tb import fsp_pkg::*;;
	logic clk = 1'b0, rst_n = 1'b0, tool_pin = 1'b0, icc_pin = 1'b0, iap_en = 1'b0, nv_prot = 1'b0;
	logic req_valid = 1'b0, req_ready, req_done, req_refused, arr_start, arr_done;
	logic [1:0] req_cmd = 2'h0, arr_cmd, arr_sector, start_sec;
	logic [15:0] req_addr = 16'h0, arr_addr, start_addr, a;
	logic [7:0] req_data = 8'h0, arr_data, start_data;
	logic [3:0] start_seq;
	logic readout_protect_option, ext_read_en, low_voltage_detector_en;
	int miscompares = 0, checks_done = 0, start_cnt;
	logic [15:0] corner [6] = '{16'hf000, 16'hffff, 16'hefff, 16'he000, 16'hdfff, 16'h1000};
	always #2 clk = ~clk;
	fsp_protect #(.FLASH_KB(60)) DUT (.clk(clk), .rst_n(rst_n), .tool_pin(tool_pin), .icc_pin(icc_pin),
		.iap_en(iap_en), .nv_prot(nv_prot), .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
		.req_data(req_data), .req_ready(req_ready), .req_done(req_done), .req_refused(req_refused),
		.arr_start(arr_start), .arr_cmd(arr_cmd), .arr_sector(arr_sector), .arr_addr(arr_addr),
		.arr_data(arr_data), .arr_done(arr_done), .readout_protect_option(readout_protect_option),
		.ext_read_en(ext_read_en), .low_voltage_detector_en(low_voltage_detector_en));
	fsp_array_model #(.FLASH_KB(60)) arr_model (.clk(clk), .rst_n(rst_n), .arr_start(arr_start),
		.arr_cmd(arr_cmd), .arr_sector(arr_sector), .arr_addr(arr_addr), .arr_data(arr_data), .arr_done(arr_done));
	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// expected sector of an address inside the array
	function automatic logic [1:0] exp_sec(input logic [15:0] x);
		return (x >= 16'hf000) ? 2'h0 : (x >= 16'he000) ? 2'h1 : 2'h2;
	endfunction : exp_sec
	// reset with a given stored option bit
	task automatic do_reset(input logic p);
		rst_n <= 1'b0;
		nv_prot <= p;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : do_reset
	// mode pins settle two cycles after a change
	task automatic set_mode(input logic t, input logic i, input logic p);
		tool_pin <= t;
		icc_pin <= i;
		iap_en <= p;
		repeat (4) @(posedge clk);
	endtask : set_mode
	// one request, outcome accepted or refused, starts recorded
	task automatic issue(input logic [1:0] c, input logic [15:0] ad, input logic [7:0] d, input logic ok);
		int n;
		logic got_done, got_ref;
		n = 0;
		got_done = 1'b0;
		got_ref = 1'b0;
		start_cnt = 0;
		start_seq = 4'h0;
		do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 50);
		check("ready", req_ready, 1'b1);
		req_valid <= 1'b1;
		req_cmd <= c;
		req_addr <= ad;
		req_data <= d;
		@(posedge clk);
		req_valid <= 1'b0;
		do begin
			@(posedge clk);
			n++;
			if (arr_start === 1'b1) begin
				if (start_cnt == 0) {start_sec, start_addr, start_data} = {arr_sector, arr_addr, arr_data};
				start_seq = {start_seq[1:0], arr_cmd};
				start_cnt++;
			end
			got_done = (req_done === 1'b1);
			got_ref = (req_refused === 1'b1);
		end while (!got_done && !got_ref && n < 120);
		check("outcome", {got_done, got_ref}, ok ? 16'h2 : 16'h1);
	endtask : issue
	task automatic status(input logic p);
		check("prot", readout_protect_option, p);
		check("ext read", ext_read_en, !p);
		check("lvd", low_voltage_detector_en, !p);
	endtask : status
	////////////////////////////////////////////////////////////////////////
	initial begin
		#(30000 * 4);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h4fd6));
		do_reset(1'b0);
		status(1'b0);
		set_mode(1'b1, 1'b0, 1'b0);
		issue(FSP_CMD_PROG, 16'hf010, 8'h5a, 1'b1);
		check("start", {start_seq, start_sec, start_addr[9:0]}, {4'h0, 2'h0, 10'h010});
		issue(FSP_CMD_PROG, 16'he020, 8'h3c, 1'b1);
		issue(FSP_CMD_ERASE_SEC, 16'he123, 8'h00, 1'b1);
		check("erase sector", start_sec, 2'h1);
		check("kept byte", arr_model.mem[16'hf010], 8'h5a);
		check("erased byte", arr_model.mem[16'he020], 8'hff);
		issue(FSP_CMD_PROG, 16'h0fff, 8'h00, 1'b0);
		foreach (corner[k]) begin
			issue(FSP_CMD_PROG, corner[k], 8'h0f, 1'b1);
			check("corner sector", start_sec, exp_sec(corner[k]));
		end
		repeat (12) begin
			a = 16'h1000 + 16'($urandom_range(16'hefff));
			issue(FSP_CMD_PROG, a, 8'($urandom), 1'b1);
			check("rand sector", start_sec, exp_sec(a));
			check("rand addr", start_addr, a);
			check("rand data", start_data, 8'(req_data));
		end
		set_mode(1'b0, 1'b0, 1'b1);
		issue(FSP_CMD_PROG, 16'hf010, 8'h00, 1'b0);
		check("untouched", arr_model.mem[16'hf010], 8'h5a);
		issue(FSP_CMD_ERASE_SEC, 16'hf800, 8'h00, 1'b0);
		issue(FSP_CMD_PROG, 16'he000, 8'h11, 1'b1);
		issue(FSP_CMD_OPT_WR, 16'h0000, 8'h01, 1'b0);
		issue(FSP_CMD_ERASE_ALL, 16'h0000, 8'h00, 1'b0);
		set_mode(1'b0, 1'b1, 1'b0);
		issue(FSP_CMD_PROG, 16'hf020, 8'h77, 1'b1);
		issue(FSP_CMD_OPT_WR, 16'h0000, 8'h01, 1'b1);
		repeat (2) @(posedge clk);
		status(1'b1);
		issue(FSP_CMD_PROG, 16'he100, 8'h00, 1'b0);
		issue(FSP_CMD_ERASE_ALL, 16'h0000, 8'h00, 1'b0);
		issue(FSP_CMD_OPT_WR, 16'h0000, 8'h00, 1'b1);
		check("clear steps", {start_cnt[3:0], start_seq}, {4'h2, 4'hb});
		check("auto erase", arr_model.mem[16'hf020], 8'hff);
		repeat (2) @(posedge clk);
		status(1'b0);
		issue(FSP_CMD_ERASE_ALL, 16'h0000, 8'h00, 1'b1);
		check("erase all", start_seq, 4'h2);
		set_mode(1'b0, 1'b0, 1'b0);
		issue(FSP_CMD_PROG, 16'he000, 8'h00, 1'b0);
		do_reset(1'b1);
		status(1'b1);
		tally_and_finish();
	end
endmodule : fsp_protect_tb
